//--- logic/ubg_defs.svh
`ifndef UBG_DEFS_SVH
`define UBG_DEFS_SVH

// Register byte addresses on the Wishbone slave
`define UBG_ADDR_TXCHAR   8'h00
`define UBG_ADDR_RXCHAR   8'h04
`define UBG_ADDR_DIVISOR  8'h08
`define UBG_ADDR_CTRL     8'h0C
`define UBG_ADDR_STATUS   8'h10

// Field positions
`define UBG_CHAR_W        9
`define UBG_NINTH_BIT     8
`define UBG_CTRL_HS       0
`define UBG_CTRL_NINE     1

// Reset values
`define UBG_DIVISOR_RST   16'h0000
`define UBG_RXCHAR_RST    9'h000

// Oversampling per bit time
`define UBG_OVS_LO        5'h10
`define UBG_OVS_HI        5'h04

// Transmit FIFO depth in words
`define UBG_FIFO_DEPTH    8

`endif

//--- logic/ubg_pkg.sv
package ubg_pkg;
  typedef logic [8:0] ubg_char_t;
  typedef enum logic [1:0] {
    UBG_IDLE  = 2'b00,
    UBG_START = 2'b01,
    UBG_DATA  = 2'b11,
    UBG_STOP  = 2'b10
  } ubg_state_e;
endpackage

//--- logic/ubg_stream_if.sv
`timescale 1ns/1ps
// Valid/ready word stream: register front end to FIFO, and FIFO to transmit shifter
interface ubg_stream_if #(parameter int WIDTH = 9);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

//--- logic/ubg_fifo.sv
`timescale 1ns/1ps
// Small synchronous FIFO; read data held in a register
module ubg_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  ubg_stream_if.sink   wr,
  ubg_stream_if.source rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic [WIDTH-1:0] out_q;
  logic             out_v;
  logic             push;
  logic             pop;
  logic             load;

  // Output register refills whenever storage holds a word and it is empty or being taken
  assign load    = (count != '0) && (!out_v || rd.ready);
  assign push    = wr.valid && wr.ready;
  assign pop     = load;
  assign wr.ready = (count != (AW+1)'(DEPTH));
  assign rd.valid = out_v;
  assign rd.data  = out_q;

  // Storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr] <= wr.data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registered read port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_v <= 1'b0;
      out_q <= '0;
    end else if (load) begin
      out_v <= 1'b1;
      out_q <= mem[rptr];
    end else if (rd.ready) begin
      out_v <= 1'b0;
    end
  end
endmodule

//--- logic/ubg_baud.sv
`timescale 1ns/1ps
`include "ubg_defs.svh"
// Baud timer plus oversampling prescaler, yields tick and bit-time pulses
module ubg_baud #(
  parameter int DIV_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             cy_en_i,
  input  wire logic [DIV_W-1:0] divisor_i,
  input  wire logic             high_speed_i,
  input  wire logic             restart_i,
  output logic                  tick_o,
  output logic                  bit_o
);
  logic [DIV_W-1:0] baud_timer;
  logic [4:0]       ovs_cnt;
  logic [4:0]       ovs_top;
  logic             wrap;

  assign ovs_top = high_speed_i ? `UBG_OVS_HI : `UBG_OVS_LO;
  assign wrap    = cy_en_i && (baud_timer == divisor_i);

  // Free-running timer, period divisor+1 instruction cycles
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      baud_timer <= '0;
    end else if (wrap) begin
      baud_timer <= '0;
    end else if (cy_en_i) begin
      baud_timer <= baud_timer + 1'b1;
    end
  end

  // Group 16 or 4 timer periods into one bit time
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      ovs_cnt <= '0;
      tick_o  <= 1'b0;
      bit_o   <= 1'b0;
    end else begin
      tick_o <= wrap;
      bit_o  <= 1'b0;
      if (wrap) begin
        if (ovs_cnt >= ovs_top - 5'h01) begin
          ovs_cnt <= '0;
          bit_o   <= 1'b1;
        end else begin
          ovs_cnt <= ovs_cnt + 5'h01;
        end
      end
    end
  end
endmodule

//--- logic/ubg_top.sv
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "ubg_defs.svh"
// Contract
// - A free-running 16-bit baud timer has its period set by the baud divisor register.
// - The baud timer advances on the instruction clock, half the system clock rate.
// - In normal speed the bit rate is the instruction clock over 16 times divisor plus one.
// - In high speed the bit rate is the instruction clock over 4 times divisor plus one.
// - Any write of the baud divisor clears the baud timer immediately.
// - Transmit character is write-only with the character in bits 7-0 and the ninth bit at 8.
// - Receive character is read-only, hardware updated, reset zero, ninth bit at 8.
// - Bits 15 to 9 of both character registers read as zero.
module ubg_top #(
  parameter int DIV_W = 16,
  parameter int DEPTH = `UBG_FIFO_DEPTH
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rx_i,
  output logic             tx_o
);
  ubg_stream_if #(.WIDTH(`UBG_CHAR_W)) wr_s ();
  ubg_stream_if #(.WIDTH(`UBG_CHAR_W)) rd_s ();

  logic [DIV_W-1:0]     baud_divisor;
  logic                 high_speed_baud_select;
  logic                 nine_bit_mode;
  ubg_pkg::ubg_char_t   receive_character;
  logic                 rx_full;
  logic                 rx_overrun;
  logic                 cy_en;
  logic                 tick;
  logic                 bit_tick;
  logic                 req;
  logic                 wr_req;
  logic                 div_wr;
  logic                 tx_wr;
  logic                 rx_rd;
  logic                 push_q;
  ubg_pkg::ubg_char_t   push_d;
  logic                 rx_done;
  ubg_pkg::ubg_char_t   rx_word;

  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_req = req && wb_we_i;
  assign div_wr = wr_req && (wb_adr_i == `UBG_ADDR_DIVISOR) && (wb_sel_i[1:0] != 2'h0);
  assign tx_wr  = wr_req && (wb_adr_i == `UBG_ADDR_TXCHAR);
  assign rx_rd  = req && !wb_we_i && (wb_adr_i == `UBG_ADDR_RXCHAR);

  // Instruction clock enable: every second system clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cy_en <= 1'b0;
    end else begin
      cy_en <= !cy_en;
    end
  end

  ubg_baud #(.DIV_W(DIV_W)) u_baud (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .cy_en_i      (cy_en),
    .divisor_i    (baud_divisor),
    .high_speed_i (high_speed_baud_select),
    .restart_i    (div_wr),
    .tick_o       (tick),
    .bit_o        (bit_tick)
  );

  // Single-cycle ack; every address answers, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h0000_0000;
      if (req && !wb_we_i) begin
        if (wb_adr_i == `UBG_ADDR_RXCHAR) begin
          wb_dat_o <= {23'h000000, receive_character};
        end else if (wb_adr_i == `UBG_ADDR_DIVISOR) begin
          wb_dat_o <= {{(32-DIV_W){1'b0}}, baud_divisor};
        end else if (wb_adr_i == `UBG_ADDR_CTRL) begin
          wb_dat_o <= {30'h0, nine_bit_mode, high_speed_baud_select};
        end else if (wb_adr_i == `UBG_ADDR_STATUS) begin
          wb_dat_o <= {28'h0000000, rx_overrun, rx_full, rd_s.valid, !wr_s.ready};
        end
      end
    end
  end

  // Divisor register, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud_divisor <= `UBG_DIVISOR_RST;
    end else if (div_wr) begin
      if (wb_sel_i[0]) begin
        baud_divisor[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        baud_divisor[DIV_W-1:8] <= wb_dat_i[DIV_W-1:8];
      end
    end
  end

  // Control bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_speed_baud_select <= 1'b0;
      nine_bit_mode          <= 1'b0;
    end else if (wr_req && (wb_adr_i == `UBG_ADDR_CTRL) && wb_sel_i[0]) begin
      high_speed_baud_select <= wb_dat_i[`UBG_CTRL_HS];
      nine_bit_mode          <= wb_dat_i[`UBG_CTRL_NINE];
    end
  end

  // Transmit write goes into FIFO; a write to a full FIFO is dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      push_q <= 1'b0;
      push_d <= '0;
    end else begin
      push_q <= tx_wr && wr_s.ready;
      if (tx_wr) begin
        push_d <= {nine_bit_mode & wb_dat_i[`UBG_NINTH_BIT], wb_dat_i[7:0]};
      end
    end
  end
  assign wr_s.valid = push_q;
  assign wr_s.data  = push_d;

  ubg_fifo #(.WIDTH(`UBG_CHAR_W), .DEPTH(DEPTH)) u_fifo (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .wr    (wr_s),
    .rd    (rd_s)
  );

  // Transmit shifter: start, 8 or 9 data bits LSB first, stop
  ubg_pkg::ubg_state_e tx_state;
  logic [8:0]          tx_sh;
  logic [3:0]          tx_cnt;
  logic                tx_take;
  assign tx_take = (tx_state == ubg_pkg::UBG_IDLE) && rd_s.valid && bit_tick;
  assign rd_s.ready = tx_take; // Shifter stalls the FIFO until idle

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state <= ubg_pkg::UBG_IDLE;
      tx_sh    <= '0;
      tx_cnt   <= '0;
      tx_o     <= 1'b1;
    end else if (bit_tick) begin
      case (tx_state)
        ubg_pkg::UBG_IDLE: begin
          tx_o <= 1'b1;
          if (rd_s.valid) begin
            tx_sh    <= rd_s.data;
            tx_o     <= 1'b0;
            tx_state <= ubg_pkg::UBG_START;
          end
        end
        ubg_pkg::UBG_START: begin
          tx_o     <= tx_sh[0];
          tx_sh    <= {1'b0, tx_sh[8:1]};
          tx_cnt   <= 4'h1;
          tx_state <= ubg_pkg::UBG_DATA;
        end
        ubg_pkg::UBG_DATA: begin
          if (tx_cnt == (nine_bit_mode ? 4'h9 : 4'h8)) begin
            tx_o     <= 1'b1;
            tx_state <= ubg_pkg::UBG_STOP;
          end else begin
            tx_o   <= tx_sh[0];
            tx_sh  <= {1'b0, tx_sh[8:1]};
            tx_cnt <= tx_cnt + 4'h1;
          end
        end
        default: begin
          tx_o     <= 1'b1;
          tx_state <= ubg_pkg::UBG_IDLE;
        end
      endcase
    end
  end

  // Receive sampler on oversampling ticks; mid-bit sample
  ubg_pkg::ubg_state_e rx_state;
  logic [4:0]          rx_ph;
  logic [3:0]          rx_cnt;
  logic [4:0]          ovs;
  logic [4:0]          half;
  assign ovs  = high_speed_baud_select ? `UBG_OVS_HI : `UBG_OVS_LO;
  assign half = {1'b0, ovs[4:1]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state <= ubg_pkg::UBG_IDLE;
      rx_ph    <= '0;
      rx_cnt   <= '0;
      rx_word  <= '0;
      rx_done  <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (tick) begin
        rx_ph <= rx_ph + 5'h01;
        case (rx_state)
          ubg_pkg::UBG_IDLE: begin
            rx_ph <= '0;
            if (!rx_i) begin
              rx_state <= ubg_pkg::UBG_START;
            end
          end
          ubg_pkg::UBG_START: begin
            if (rx_ph == half - 5'h01) begin
              rx_ph    <= '0;
              rx_cnt   <= '0;
              rx_word  <= '0;
              rx_state <= rx_i ? ubg_pkg::UBG_IDLE : ubg_pkg::UBG_DATA;
            end
          end
          ubg_pkg::UBG_DATA: begin
            if (rx_ph == ovs - 5'h01) begin
              rx_ph   <= '0;
              rx_word <= nine_bit_mode ? {rx_i, rx_word[8:1]} : {1'b0, rx_i, rx_word[7:1]};
              rx_cnt  <= rx_cnt + 4'h1;
              if (rx_cnt == (nine_bit_mode ? 4'h8 : 4'h7)) begin
                rx_state <= ubg_pkg::UBG_STOP;
              end
            end
          end
          default: begin
            if (rx_ph == ovs - 5'h01) begin
              rx_done  <= rx_i; // Framing error drops the character
              rx_state <= ubg_pkg::UBG_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Receive character register and status; new data wins over a read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      receive_character <= `UBG_RXCHAR_RST;
      rx_full           <= 1'b0;
      rx_overrun        <= 1'b0;
    end else if (rx_done) begin
      receive_character <= rx_word;
      rx_full           <= 1'b1;
      rx_overrun        <= rx_overrun | rx_full;
    end else if (rx_rd) begin
      rx_full    <= 1'b0;
      rx_overrun <= 1'b0;
    end
  end
endmodule

//--- testbench/ubg_monitor.sv
`timescale 1ns/1ps
`include "ubg_defs.svh"
// Bus and line checks on the top ports
module ubg_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        rx_i,
  input wire logic        tx_o
);
  logic [15:0] div;
  logic        hs;
  int          low_run;
  int          bit_len;
  // Rate shadow; full byte lanes assumed, as the bench always drives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div <= 16'h0000;
      hs <= 1'b0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o) begin
      if (wb_adr_i == `UBG_ADDR_DIVISOR) div <= wb_dat_i[15:0];
      if (wb_adr_i == `UBG_ADDR_CTRL) hs <= wb_dat_i[0];
    end
  end
  // Low runs only: high runs span idle time between frames
  always_ff @(posedge clk_i) begin
    if (rst_i || tx_o) low_run <= 0;
    else low_run <= low_run + 1;
  end
  assign bit_len = hs ? 8 * (div + 1) : 32 * (div + 1);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence rd_s; wb_ack_o && !wb_we_i; endsequence
  ack_answer_a: assert property (req_s |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack late or too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without request");
  dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack");
  upper_zero_a: assert property (
    rd_s ##0 (wb_adr_i == `UBG_ADDR_TXCHAR || wb_adr_i == `UBG_ADDR_RXCHAR)
    |-> wb_dat_o[31:9] == 23'h000000) else $error("char upper bits set");
  tx_readzero_a: assert property (rd_s ##0 (wb_adr_i == `UBG_ADDR_TXCHAR)
    |-> wb_dat_o == 32'h00000000) else $error("transmit char readable");
  div_readback_a: assert property (rd_s ##0 (wb_adr_i == `UBG_ADDR_DIVISOR)
    |-> wb_dat_o == {16'h0000, div}) else $error("divisor readback wrong");
  tx_bitlen_a: assert property ($rose(tx_o)
    |-> low_run != 0 && low_run % bit_len == 0) else $error("bit time wrong");
  reset_idle_a: assert property (disable iff (1'b0) rst_i |=> tx_o && !wb_ack_o)
    else $error("not idle in reset");
endmodule

bind ubg_top ubg_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_i(rx_i), .tx_o(tx_o));

//--- testbench/ubg_remote.sv
`timescale 1ns/1ps
// Remote transceiver at the far end of the serial line
module ubg_remote (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  int         nbits = 9;
  int         width;
  int         frames = 0;
  logic [8:0] got;
  int         i;
  initial line_o = 1'b1;
  // Start bit sets the bit time; needs bit 0 high. Falling edge samples
  always begin
    @(negedge line_i);
    @(negedge clk_i);
    width = 0;
    while (line_i === 1'b0) begin
      width++;
      @(negedge clk_i);
    end
    got = 9'h000;
    for (i = 0; i < nbits; i++) begin
      repeat (width / 2) @(negedge clk_i);
      got[i] = line_i;
      repeat (width - width / 2) @(negedge clk_i);
    end
    repeat (width / 2) @(negedge clk_i);
    frames++;
  end
  // Sends one frame, LSB first, at w clocks a bit
  task automatic send(input logic [8:0] c, input int nb, input int w);
    int k;
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (w) @(posedge clk_i);
    for (k = 0; k < nb; k++) begin
      line_o <= c[k];
      repeat (w) @(posedge clk_i);
    end
    line_o <= 1'b1;
    repeat (w) @(posedge clk_i);
  endtask
endmodule

//--- testbench/ubg_top_bench.sv
`timescale 1ns/1ps
`include "ubg_defs.svh"
module ubg_top_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack;
  logic        rx;
  logic        tx;
  int          errors = 0;
  int          tests_run = 0;
  int          i;
  ubg_top dut_u (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rx_i(rx), .tx_o(tx));
  ubg_remote rem_u (.clk_i(clk), .line_i(tx), .line_o(rx));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // One classic cycle; held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, well above the few thousand cycles needed
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    bus(0, `UBG_ADDR_RXCHAR, 0);
    chk("rx reset", 0, q);
    bus(0, `UBG_ADDR_DIVISOR, 0);
    chk("div reset", 0, q);
    // Nine-bit, normal speed, divisor 1: 64 clocks a bit
    bus(1, `UBG_ADDR_CTRL, 2);
    bus(1, `UBG_ADDR_DIVISOR, 1);
    bus(0, `UBG_ADDR_DIVISOR, 0);
    chk("div", 1, q);
    bus(1, `UBG_ADDR_TXCHAR, 32'h0000FFA5);
    wait (rem_u.frames == 1);
    chk("tx char", 32'h1A5, rem_u.got);
    chk("bit time", 64, rem_u.width);
    bus(0, `UBG_ADDR_TXCHAR, 0);
    chk("tx read", 0, q);
    rem_u.send(9'h0C3, 9, 64);
    bus(0, `UBG_ADDR_STATUS, 0);
    chk("rx full", 32'h4, q & 32'hC);
    bus(0, `UBG_ADDR_RXCHAR, 0);
    chk("rx char", 32'h0C3, q);
    bus(0, `UBG_ADDR_STATUS, 0);
    chk("rx flags clear", 0, q & 32'hC);
    bus(0, 8'h20, 0);
    chk("unmapped", 0, q);
    // High speed with a rewritten divisor: 24 clocks a bit
    bus(1, `UBG_ADDR_CTRL, 3);
    bus(1, `UBG_ADDR_DIVISOR, 2);
    bus(1, `UBG_ADDR_TXCHAR, 32'h00000155);
    wait (rem_u.frames == 2);
    chk("hs bit time", 24, rem_u.width);
    chk("hs char", 32'h155, rem_u.got);
    // Eight-bit mode, fastest rate; overfill the FIFO, then drain
    rem_u.nbits = 8;
    bus(1, `UBG_ADDR_CTRL, 1);
    bus(1, `UBG_ADDR_DIVISOR, 0);
    for (i = 0; i < 12; i++) bus(1, `UBG_ADDR_TXCHAR, 32'h000001FF);
    bus(0, `UBG_ADDR_STATUS, 0);
    chk("fifo full", 1, q & 32'h1);
    wait (rem_u.frames == 3);
    chk("eight bit char", 32'h0FF, rem_u.got);
    chk("fast bit time", 8, rem_u.width);
    do bus(0, `UBG_ADDR_STATUS, 0); while (q[1:0] !== 2'b00);
    chk("drained", 0, q & 32'h3);
    conclude();
  end
endmodule
